// ---- rtl/cbae_map.svh ----
// constants for the bit and atomic execution unit: offsets, field positions, resets, pointer steps
// Notes on behaviour
// (RULE_01) program store writes R1:R0, then Z plus two
// (RULE_02) io in/out copies byte, one cycle, flags kept
// (RULE_03) push stores register, one cycle, flags kept
// (RULE_04) pop loads register, two cycles, flags kept
// (RULE_05) or-update returns old byte, writes or
// (RULE_06) bitclear-update returns old, writes old and not reg
// (RULE_07) xor-update returns old byte, writes xor
// (RULE_08) left rotate through carry, updates z c n v h
// (RULE_09) right rotate through carry, updates z c n v
// (RULE_10) io bit force one, one cycle, flags kept
// (RULE_11) io bit force zero, one cycle, flags kept
// (RULE_12) register bit copied to transfer flag only
// (RULE_13) transfer flag copied to register bit
// (RULE_14) dedicated ops set or clear overflow only
// (RULE_15) dedicated ops set or clear sign only
// (RULE_16) dedicated ops set or clear halfcarry only
// (RULE_17) sram loads take one extra cycle
// (RULE_18) external ram accesses may take longer
// (RULE_19) control ops take one cycle, flags kept
// (RULE_20) atomic swap exchanges register and ram, two cycles
// (RULE_21) logic shifts insert zero, signed shift keeps msb
// (RULE_22) nibble swap exchanges halves, flags kept
`ifndef CBAE_MAP_SVH
`define CBAE_MAP_SVH
// status flag bit positions
`define CBAE_FLG_C     0
`define CBAE_FLG_Z     1
`define CBAE_FLG_N     2
`define CBAE_FLG_V     3
`define CBAE_FLG_S     4
`define CBAE_FLG_H     5
`define CBAE_FLG_T     6
// register port map: regions and misc offsets
`define CBAE_RGN_GPR   2'h0
`define CBAE_RGN_IO    2'h1
`define CBAE_RGN_MISC  2'h2
`define CBAE_OFS_FLAGS 3'h0
`define CBAE_OFS_SP_LO 3'h1
`define CBAE_OFS_SP_HI 3'h2
`define CBAE_OFS_PAGE  3'h3
// reset values
`define CBAE_RST_FLAGS 8'h00
`define CBAE_RST_SP    16'h0FFF
`define CBAE_RST_PAGE  8'h00
// pointer steps
`define CBAE_PMEM_STEP 24'h00_0002
`define CBAE_SP_STEP   16'h0001
`endif

// ---- rtl/cbae_pkg.sv ----
// types for the bit and atomic execution unit
package cbae_pkg;
   // operation codes presented by the decoder
   typedef enum logic [4:0] {
      OP_IDLE_OP, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP, OP_DATA_LOAD,
      OP_ATOMIC_SWAP, OP_ATOMIC_OR_UPDATE, OP_ATOMIC_BITCLEAR_UPDATE, OP_ATOMIC_XOR_UPDATE,
      OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_CARRY_LEFT_ROTATE, OP_CARRY_RIGHT_ROTATE,
      OP_SIGNED_RIGHT_SHIFT, OP_NIBBLE_SWAP, OP_FLAG_FORCE_ONE, OP_FLAG_FORCE_ZERO,
      OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO, OP_BIT_TO_TRANSFER_FLAG,
      OP_TRANSFER_FLAG_TO_BIT, OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR,
      OP_SIGN_FLAG_SET, OP_SIGN_FLAG_CLEAR, OP_HALFCARRY_FLAG_SET, OP_HALFCARRY_FLAG_CLEAR,
      OP_BREAK, OP_SLEEP, OP_WATCHDOG_RESTART, OP_PROGRAM_MEMORY_STORE
   } cbae_op_t;
   // sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_RUN    = 2'b01,
      ST_RDWAIT = 2'b10
   } cbae_state_t;
   // whole state of the unit
   typedef struct packed {
      cbae_state_t     state;
      logic            ready;
      logic            done;
      logic [31:0][7:0] rf;
      logic [31:0][7:0] io;
      logic [7:0]      flags;
      logic [15:0]     sp;
      logic [7:0]      page;
      logic [15:0]     ram_addr;
      logic [7:0]      ram_wdata;
      logic            ram_we;
      logic            ram_re;
      logic [23:0]     pmem_addr;
      logic [15:0]     pmem_wdata;
      logic            pmem_we;
      logic [7:0]      rdata;
      logic            brk;
      logic            slp;
      logic            wdog;
      cbae_op_t        pend_op;
      logic [4:0]      pend_rd;
      logic [3:0]      wait_cnt;
   } cbae_st_t;
endpackage

// ---- rtl/cbae_exec.sv ----
// bit, shift, stack and atomic memory execution unit with register port
`timescale 1ns/1ps
`include "cbae_map.svh"
module cbae_exec #(
   parameter logic [3:0] EXT_WAIT = 4'h1   // extra read cycles on external ram
) (
   input  wire logic             MCLK,
   input  wire logic             RESET_N,
   input  wire logic             OP_VALID,
   input  wire cbae_pkg::cbae_op_t OP_CODE,
   input  wire logic [4:0]       OP_RD,
   input  wire logic [4:0]       OP_RR,
   input  wire logic [2:0]       OP_BIT,
   input  wire logic [4:0]       OP_IO_ADDR,
   input  wire logic             OP_EXT_RAM,
   input  wire logic [7:0]       RAM_RDATA,
   input  wire logic [6:0]       REG_ADDR,
   input  wire logic [7:0]       REG_WDATA,
   input  wire logic             REG_WR,
   input  wire logic             REG_RD,
   output logic                  OP_READY,
   output logic                  OP_DONE,
   output logic [15:0]           RAM_ADDR,
   output logic [7:0]            RAM_WDATA,
   output logic                  RAM_WE,
   output logic                  RAM_RE,
   output logic [23:0]           PMEM_ADDR,
   output logic [15:0]           PMEM_WDATA,
   output logic                  PMEM_WE,
   output logic [7:0]            REG_RDATA,
   output logic [7:0]            STATUS_FLAGS,
   output logic                  BREAK_HIT,
   output logic                  SLEEP_REQ,
   output logic                  WDOG_RESTART
);
   import cbae_pkg::*;

   cbae_st_t    st_r;      // registered state
   cbae_st_t    st_nxt;    // next state
   logic        accept;    // operation taken this cycle
   logic [7:0]  rd_v;      // destination operand
   logic [7:0]  rr_v;      // source operand
   logic [15:0] zp_v;      // z pointer from r31:r30
   logic [7:0]  old_v;     // old register of pending atomic
   logic [7:0]  sh_v;      // shift result

   // flags after a shift: z, c, n, v, s, optional h
   function automatic logic [7:0] shift_flags(input logic [7:0] fl, input logic [7:0] res,
                                              input logic c, input logic upd_h,
                                              input logic h);
      logic [7:0] f;
      f = fl;
      f[`CBAE_FLG_Z] = (res == 8'h00);
      f[`CBAE_FLG_C] = c;
      f[`CBAE_FLG_N] = res[7];
      f[`CBAE_FLG_V] = res[7] ^ c;
      f[`CBAE_FLG_S] = res[7] ^ (res[7] ^ c);
      if (upd_h) begin
         f[`CBAE_FLG_H] = h;
      end
      return f;
   endfunction

   // outputs straight from state flops
   assign OP_READY     = st_r.ready;
   assign OP_DONE      = st_r.done;
   assign RAM_ADDR     = st_r.ram_addr;
   assign RAM_WDATA    = st_r.ram_wdata;
   assign RAM_WE       = st_r.ram_we;
   assign RAM_RE       = st_r.ram_re;
   assign PMEM_ADDR    = st_r.pmem_addr;
   assign PMEM_WDATA   = st_r.pmem_wdata;
   assign PMEM_WE      = st_r.pmem_we;
   assign REG_RDATA    = st_r.rdata;
   assign STATUS_FLAGS = st_r.flags;
   assign BREAK_HIT    = st_r.brk;
   assign SLEEP_REQ    = st_r.slp;
   assign WDOG_RESTART = st_r.wdog;

   // next-state logic
   always_comb begin
      st_nxt     = st_r;
      accept     = OP_VALID && st_r.ready && (st_r.state == ST_RUN);
      rd_v       = st_r.rf[OP_RD];
      rr_v       = st_r.rf[OP_RR];
      zp_v       = {st_r.rf[31], st_r.rf[30]};
      old_v      = st_r.rf[st_r.pend_rd];
      sh_v       = 8'h00;
      // single-cycle pulses drop by default
      st_nxt.done    = 1'b0;
      st_nxt.ram_we  = 1'b0;
      st_nxt.pmem_we = 1'b0;
      st_nxt.brk     = 1'b0;
      st_nxt.slp     = 1'b0;
      st_nxt.wdog    = 1'b0;
      st_nxt.rdata   = 8'h00;
      case (st_r.state)
         ST_RUN: begin
            if (accept) begin
               st_nxt.done = 1'b1;
               case (OP_CODE)
                  // io moves, flags kept
                  OP_IO_IN: begin
                     st_nxt.rf[OP_RD] = st_r.io[OP_IO_ADDR]; // RULE_02
                  end
                  OP_IO_OUT: begin
                     st_nxt.io[OP_IO_ADDR] = rr_v; // RULE_02
                  end
                  // push: write at sp, then post-decrement
                  OP_PUSH: begin
                     st_nxt.ram_addr  = st_r.sp; // RULE_03
                     st_nxt.ram_wdata = rr_v;
                     st_nxt.ram_we    = 1'b1;
                     st_nxt.sp        = st_r.sp - `CBAE_SP_STEP;
                  end
                  // pop: pre-increment then read, second cycle loads
                  OP_POP: begin
                     st_nxt.sp       = st_r.sp + `CBAE_SP_STEP; // RULE_04
                     st_nxt.ram_addr = st_r.sp + `CBAE_SP_STEP;
                     st_nxt.ram_re   = 1'b1;
                     st_nxt.state    = ST_RDWAIT;
                     st_nxt.ready    = 1'b0;
                     st_nxt.done     = 1'b0;
                     st_nxt.pend_op  = OP_CODE;
                     st_nxt.pend_rd  = OP_RD;
                     st_nxt.wait_cnt = OP_EXT_RAM ? EXT_WAIT : 4'h0; // RULE_18
                  end
                  // z-addressed reads: plain sram load and atomic updates
                  OP_DATA_LOAD, OP_ATOMIC_SWAP, OP_ATOMIC_OR_UPDATE,
                  OP_ATOMIC_BITCLEAR_UPDATE, OP_ATOMIC_XOR_UPDATE: begin
                     st_nxt.ram_addr = zp_v; // RULE_17
                     st_nxt.ram_re   = 1'b1;
                     st_nxt.state    = ST_RDWAIT;
                     st_nxt.ready    = 1'b0;
                     st_nxt.done     = 1'b0;
                     st_nxt.pend_op  = OP_CODE;
                     st_nxt.pend_rd  = OP_RD;
                     st_nxt.wait_cnt = OP_EXT_RAM ? EXT_WAIT : 4'h0; // RULE_18
                  end
                  // shifts and rotates
                  OP_LOGIC_LEFT_SHIFT: begin
                     sh_v = {rd_v[6:0], 1'b0}; // RULE_21
                     st_nxt.rf[OP_RD] = sh_v;
                     st_nxt.flags = shift_flags(st_r.flags, sh_v, rd_v[7], 1'b1, rd_v[3]);
                  end
                  OP_LOGIC_RIGHT_SHIFT: begin
                     sh_v = {1'b0, rd_v[7:1]}; // RULE_21
                     st_nxt.rf[OP_RD] = sh_v;
                     st_nxt.flags = shift_flags(st_r.flags, sh_v, rd_v[0], 1'b0, 1'b0);
                  end
                  OP_CARRY_LEFT_ROTATE: begin
                     sh_v = {rd_v[6:0], st_r.flags[`CBAE_FLG_C]}; // RULE_08
                     st_nxt.rf[OP_RD] = sh_v;
                     st_nxt.flags = shift_flags(st_r.flags, sh_v, rd_v[7], 1'b1, rd_v[3]);
                  end
                  OP_CARRY_RIGHT_ROTATE: begin
                     sh_v = {st_r.flags[`CBAE_FLG_C], rd_v[7:1]}; // RULE_09
                     st_nxt.rf[OP_RD] = sh_v;
                     st_nxt.flags = shift_flags(st_r.flags, sh_v, rd_v[0], 1'b0, 1'b0);
                  end
                  OP_SIGNED_RIGHT_SHIFT: begin
                     sh_v = {rd_v[7], rd_v[7:1]}; // RULE_21
                     st_nxt.rf[OP_RD] = sh_v;
                     st_nxt.flags = shift_flags(st_r.flags, sh_v, rd_v[0], 1'b0, 1'b0);
                  end
                  OP_NIBBLE_SWAP: begin
                     st_nxt.rf[OP_RD] = {rd_v[3:0], rd_v[7:4]}; // RULE_22
                  end
                  // generic status bit force
                  OP_FLAG_FORCE_ONE: begin
                     st_nxt.flags[OP_BIT] = 1'b1;
                  end
                  OP_FLAG_FORCE_ZERO: begin
                     st_nxt.flags[OP_BIT] = 1'b0;
                  end
                  // io bit force, flags kept
                  OP_IO_BIT_FORCE_ONE: begin
                     st_nxt.io[OP_IO_ADDR][OP_BIT] = 1'b1; // RULE_10
                  end
                  OP_IO_BIT_FORCE_ZERO: begin
                     st_nxt.io[OP_IO_ADDR][OP_BIT] = 1'b0; // RULE_11
                  end
                  // transfer flag moves
                  OP_BIT_TO_TRANSFER_FLAG: begin
                     st_nxt.flags[`CBAE_FLG_T] = st_r.rf[OP_RR][OP_BIT]; // RULE_12
                  end
                  OP_TRANSFER_FLAG_TO_BIT: begin
                     st_nxt.rf[OP_RD][OP_BIT] = st_r.flags[`CBAE_FLG_T]; // RULE_13
                  end
                  // dedicated single-flag ops
                  OP_OVERFLOW_FLAG_SET: begin
                     st_nxt.flags[`CBAE_FLG_V] = 1'b1; // RULE_14
                  end
                  OP_OVERFLOW_FLAG_CLEAR: begin
                     st_nxt.flags[`CBAE_FLG_V] = 1'b0; // RULE_14
                  end
                  OP_SIGN_FLAG_SET: begin
                     st_nxt.flags[`CBAE_FLG_S] = 1'b1; // RULE_15
                  end
                  OP_SIGN_FLAG_CLEAR: begin
                     st_nxt.flags[`CBAE_FLG_S] = 1'b0; // RULE_15
                  end
                  OP_HALFCARRY_FLAG_SET: begin
                     st_nxt.flags[`CBAE_FLG_H] = 1'b1; // RULE_16
                  end
                  OP_HALFCARRY_FLAG_CLEAR: begin
                     st_nxt.flags[`CBAE_FLG_H] = 1'b0; // RULE_16
                  end
                  // control ops: one cycle, event pulse only
                  OP_BREAK: begin
                     st_nxt.brk = 1'b1; // RULE_19
                  end
                  OP_SLEEP: begin
                     st_nxt.slp = 1'b1; // RULE_19
                  end
                  OP_WATCHDOG_RESTART: begin
                     st_nxt.wdog = 1'b1; // RULE_19
                  end
                  // program word store, extended z advanced by two
                  OP_PROGRAM_MEMORY_STORE: begin
                     st_nxt.pmem_addr  = {st_r.page, zp_v}; // RULE_01
                     st_nxt.pmem_wdata = {st_r.rf[1], st_r.rf[0]};
                     st_nxt.pmem_we    = 1'b1;
                     {st_nxt.page, st_nxt.rf[31], st_nxt.rf[30]} =
                        {st_r.page, zp_v} + `CBAE_PMEM_STEP;
                  end
                  default: begin
                     // idle op: nothing but the done pulse
                  end
               endcase
            end
         end
         ST_RDWAIT: begin
            if (st_r.wait_cnt != 4'h0) begin
               // external ram still answering
               st_nxt.wait_cnt = st_r.wait_cnt - 4'h1; // RULE_18
            end else begin
               // data valid: load register, post write-back if atomic
               st_nxt.ram_re            = 1'b0;
               st_nxt.state             = ST_RUN;
               st_nxt.ready             = 1'b1;
               st_nxt.done              = 1'b1;
               st_nxt.rf[st_r.pend_rd]  = RAM_RDATA; // RULE_04 RULE_17
               case (st_r.pend_op)
                  OP_ATOMIC_SWAP: begin
                     st_nxt.ram_we    = 1'b1; // RULE_20
                     st_nxt.ram_wdata = old_v;
                  end
                  OP_ATOMIC_OR_UPDATE: begin
                     st_nxt.ram_we    = 1'b1; // RULE_05
                     st_nxt.ram_wdata = old_v | RAM_RDATA;
                  end
                  OP_ATOMIC_BITCLEAR_UPDATE: begin
                     st_nxt.ram_we    = 1'b1; // RULE_06
                     st_nxt.ram_wdata = (8'hFF - old_v) & RAM_RDATA;
                  end
                  OP_ATOMIC_XOR_UPDATE: begin
                     st_nxt.ram_we    = 1'b1; // RULE_07
                     st_nxt.ram_wdata = old_v ^ RAM_RDATA;
                  end
                  default: begin
                     // pop and plain load: no write-back
                  end
               endcase
            end
         end
         default: begin
            // illegal encoding: back to idle
            st_nxt.state  = ST_RUN;
            st_nxt.ready  = 1'b1;
            st_nxt.ram_re = 1'b0;
         end
      endcase
      // software register port, applied after the operation
      if (REG_WR) begin
         case (REG_ADDR[6:5])
            `CBAE_RGN_GPR: st_nxt.rf[REG_ADDR[4:0]] = REG_WDATA;
            `CBAE_RGN_IO:  st_nxt.io[REG_ADDR[4:0]] = REG_WDATA;
            `CBAE_RGN_MISC: begin
               case (REG_ADDR[2:0])
                  `CBAE_OFS_FLAGS: st_nxt.flags     = REG_WDATA;
                  `CBAE_OFS_SP_LO: st_nxt.sp[7:0]   = REG_WDATA;
                  `CBAE_OFS_SP_HI: st_nxt.sp[15:8]  = REG_WDATA;
                  `CBAE_OFS_PAGE:  st_nxt.page      = REG_WDATA;
                  default: begin
                     // unmapped: ignored
                  end
               endcase
            end
            default: begin
               // unmapped region: ignored
            end
         endcase
      end
      // read data for the following cycle only
      if (REG_RD) begin
         case (REG_ADDR[6:5])
            `CBAE_RGN_GPR: st_nxt.rdata = st_r.rf[REG_ADDR[4:0]];
            `CBAE_RGN_IO:  st_nxt.rdata = st_r.io[REG_ADDR[4:0]];
            `CBAE_RGN_MISC: begin
               case (REG_ADDR[2:0])
                  `CBAE_OFS_FLAGS: st_nxt.rdata = st_r.flags;
                  `CBAE_OFS_SP_LO: st_nxt.rdata = st_r.sp[7:0];
                  `CBAE_OFS_SP_HI: st_nxt.rdata = st_r.sp[15:8];
                  `CBAE_OFS_PAGE:  st_nxt.rdata = st_r.page;
                  default:         st_nxt.rdata = 8'h00;
               endcase
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r          <= '0;
         st_r.state    <= ST_RUN;
         st_r.ready    <= 1'b1;
         st_r.flags    <= `CBAE_RST_FLAGS;
         st_r.sp       <= `CBAE_RST_SP;
         st_r.page     <= `CBAE_RST_PAGE;
         st_r.pend_op  <= OP_IDLE_OP;
      end else begin
         st_r <= st_nxt;
      end
   end

   // checks on the execution behaviour
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   property p_pmem_store;
      accept && OP_CODE == OP_PROGRAM_MEMORY_STORE && !REG_WR |=>
         PMEM_WE && PMEM_WDATA == $past({st_r.rf[1], st_r.rf[0]}) &&
         {st_r.page, st_r.rf[31], st_r.rf[30]} == PMEM_ADDR + `CBAE_PMEM_STEP;
   endproperty
   a_pmem_store: assert property (p_pmem_store) else $error("program store bad"); // RULE_01

   property p_io_in;
      accept && OP_CODE == OP_IO_IN && !REG_WR |=>
         st_r.rf[$past(OP_RD)] == $past(st_r.io[OP_IO_ADDR]) && $stable(st_r.flags) && OP_READY;
   endproperty
   a_io_in: assert property (p_io_in) else $error("io input bad"); // RULE_02

   property p_push;
      accept && OP_CODE == OP_PUSH && !REG_WR |=>
         RAM_WE && RAM_ADDR == $past(st_r.sp) && RAM_WDATA == $past(rr_v) && OP_READY;
   endproperty
   a_push: assert property (p_push) else $error("push bad"); // RULE_03

   property p_pop_time;
      accept && OP_CODE == OP_POP && !OP_EXT_RAM |=> RAM_RE && !OP_READY ##1 OP_READY && OP_DONE;
   endproperty
   a_pop_time: assert property (p_pop_time) else $error("pop timing bad"); // RULE_04

   property p_atomic_or;
      st_r.state == ST_RDWAIT && st_r.wait_cnt == 4'h0 && st_r.pend_op == OP_ATOMIC_OR_UPDATE
         |=> RAM_WE && RAM_WDATA == ($past(RAM_RDATA) | $past(old_v));
   endproperty
   a_atomic_or: assert property (p_atomic_or) else $error("or update bad"); // RULE_05

   property p_atomic_clr;
      st_r.state == ST_RDWAIT && st_r.wait_cnt == 4'h0 &&
         st_r.pend_op == OP_ATOMIC_BITCLEAR_UPDATE
         |=> RAM_WE && RAM_WDATA == ($past(RAM_RDATA) & ~$past(old_v));
   endproperty
   a_atomic_clr: assert property (p_atomic_clr) else $error("bitclear update bad"); // RULE_06

   property p_left_rotate;
      accept && OP_CODE == OP_CARRY_LEFT_ROTATE && !REG_WR |=>
         st_r.rf[$past(OP_RD)] == {$past(rd_v[6:0]), $past(st_r.flags[`CBAE_FLG_C])} &&
         st_r.flags[`CBAE_FLG_C] == $past(rd_v[7]) && st_r.flags[`CBAE_FLG_H] == $past(rd_v[3]);
   endproperty
   a_left_rotate: assert property (p_left_rotate) else $error("left rotate bad"); // RULE_08

   property p_io_bit_one;
      accept && OP_CODE == OP_IO_BIT_FORCE_ONE && !REG_WR |=>
         st_r.io[$past(OP_IO_ADDR)][$past(OP_BIT)] && $stable(st_r.flags);
   endproperty
   a_io_bit_one: assert property (p_io_bit_one) else $error("io bit set bad"); // RULE_10

   property p_bit_to_t;
      accept && OP_CODE == OP_BIT_TO_TRANSFER_FLAG && !REG_WR |=>
         st_r.flags[`CBAE_FLG_T] == $past(st_r.rf[OP_RR][OP_BIT]) &&
         st_r.flags[5:0] == $past(st_r.flags[5:0]);
   endproperty
   a_bit_to_t: assert property (p_bit_to_t) else $error("transfer flag store bad"); // RULE_12

   property p_v_set;
      accept && OP_CODE == OP_OVERFLOW_FLAG_SET && !REG_WR |=>
         STATUS_FLAGS == ($past(STATUS_FLAGS) | 8'h08);
   endproperty
   a_v_set: assert property (p_v_set) else $error("overflow set bad"); // RULE_14

   property p_ctrl;
      accept && OP_CODE == OP_BREAK && !REG_WR |=> BREAK_HIT && OP_READY && $stable(st_r.flags);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("break op bad"); // RULE_19
endmodule

// ---- sim/cbae_mem.sv ----
// data memory model facing the execution unit
`timescale 1ns/1ps
module cbae_mem (
   input  wire logic        MCLK,
   input  wire logic [15:0] RAM_ADDR,
   input  wire logic [7:0]  RAM_WDATA,
   input  wire logic        RAM_WE,
   input  wire logic        RAM_RE,
   output logic [7:0]       RAM_RDATA
);
   logic [7:0] mem [0:4095];   // internal ram, 4k bytes
   logic [7:0] last_r;         // last byte driven while reading
   // preload a known pattern: byte equals low address xor 5A
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      last_r = 8'h00;
   end
   // answer within the same cycle; inverted junk when not read
   assign RAM_RDATA = RAM_RE ? mem[RAM_ADDR[11:0]] : ~last_r;
   // posted writes land at the edge; remember read data
   always @(posedge MCLK) begin
      if (RAM_WE) begin
         mem[RAM_ADDR[11:0]] <= RAM_WDATA;
      end
      if (RAM_RE) begin
         last_r <= mem[RAM_ADDR[11:0]];
      end
   end
endmodule

// ---- sim/cpu_bit_atomic_ops_exec_test.sv ----
// self-checking testbench for the bit and atomic execution unit
`timescale 1ns/1ps
module cpu_bit_atomic_ops_exec_test;
   import cbae_pkg::*;
   logic MCLK, RESET_N, OP_VALID, OP_EXT_RAM, REG_WR, REG_RD, OP_READY, OP_DONE;
   logic RAM_WE, RAM_RE, PMEM_WE, BREAK_HIT, SLEEP_REQ, WDOG_RESTART;
   cbae_op_t OP_CODE;
   logic [4:0] OP_RD, OP_RR, OP_IO_ADDR;
   logic [2:0] OP_BIT, pul;
   logic [6:0] REG_ADDR;
   logic [7:0] REG_WDATA, RAM_RDATA, RAM_WDATA, REG_RDATA, STATUS_FLAGS, old;
   logic [15:0] RAM_ADDR, PMEM_WDATA;
   logic [23:0] PMEM_ADDR;
   int miscompares = 0, samples_checked = 0, ticks = 0;
   cbae_op_t tbl [6];
   logic [7:0] er [6];
   logic [7:0] ef [6];
   cbae_exec u_cbae_exec (.*);
   cbae_mem u_cbae_mem (.MCLK(MCLK), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
      .RAM_WE(RAM_WE), .RAM_RE(RAM_RE), .RAM_RDATA(RAM_RDATA));
   // 250 MHz clock
   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end
   // verdict and end of run
   task automatic finish_test();
      $display("compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // hang guard
   always @(posedge MCLK) begin
      ticks++;
      if (ticks == 4000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle register port write
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge MCLK);
      REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= d;
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   // read, data checked in the following cycle
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge MCLK);
      REG_RD <= 1'b1; REG_ADDR <= a;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      #1 chk8(REG_RDATA, e);
   endtask
   // present one op, count cycles until done, latch pulses at done
   task automatic run(input cbae_op_t op, input logic [4:0] d, input logic [4:0] r,
                      input logic [2:0] b, input logic [4:0] io, input logic x,
                      input logic [7:0] cyc_exp);
      logic [7:0] cyc;
      cyc = 8'h01;
      @(posedge MCLK);
      OP_VALID <= 1'b1; OP_CODE <= op; OP_RD <= d; OP_RR <= r; OP_BIT <= b;
      OP_IO_ADDR <= io; OP_EXT_RAM <= x;
      @(posedge MCLK);
      OP_VALID <= 1'b0;
      #1;
      while (OP_DONE !== 1'b1 && cyc < 8'h10) begin
         cyc++;
         @(posedge MCLK);
         #1;
      end
      pul = {BREAK_HIT, SLEEP_REQ, WDOG_RESTART};
      chk8(cyc, cyc_exp);
   endtask
   initial begin
      {RESET_N, OP_VALID, OP_EXT_RAM, REG_WR, REG_RD} = 5'h00;
      {OP_RD, OP_RR, OP_BIT, OP_IO_ADDR, REG_ADDR, REG_WDATA} = 33'h0;
      OP_CODE = OP_IDLE_OP;
      repeat (8) @(posedge MCLK);
      RESET_N <= 1'b1;
      rd(7'h40, 8'h00); rd(7'h41, 8'hFF); rd(7'h42, 8'h0F); rd(7'h43, 8'h00);
      wr(7'h7F, 8'hAA); rd(7'h7F, 8'h00);
      // atomics on Z = 0x0010..0x0013, register holds 0F
      for (int i = 0; i < 4; i++) begin
         old = 8'h5A ^ (8'h10 + 8'(i));
         wr(7'h10, 8'h0F);
         wr(7'h1E, 8'h10 + 8'(i));
         run(cbae_op_t'(6 + i), 5'h10, 5'h00, 3'h0, 5'h00, 1'b0, 8'h02);
         chk8(STATUS_FLAGS, 8'h00);
         rd(7'h10, old);
         er[0] = (i == 0) ? 8'h0F : (i == 1) ? old | 8'h0F : (i == 2) ? old & 8'hF0 : old ^ 8'h0F;
         chk8(u_cbae_mem.mem[12'h010 + 12'(i)], er[0]);
      end
      // loads: internal then external ram
      wr(7'h1E, 8'h20);
      run(OP_DATA_LOAD, 5'h0B, 5'h00, 3'h0, 5'h00, 1'b0, 8'h02);
      run(OP_DATA_LOAD, 5'h0C, 5'h00, 3'h0, 5'h00, 1'b1, 8'h03);
      rd(7'h0C, 8'h7A);
      // stack, io moves, io bits
      wr(7'h05, 8'hA5);
      run(OP_PUSH, 5'h00, 5'h05, 3'h0, 5'h00, 1'b0, 8'h01);
      rd(7'h41, 8'hFE); chk8(u_cbae_mem.mem[12'hFFF], 8'hA5);
      run(OP_POP, 5'h06, 5'h00, 3'h0, 5'h00, 1'b0, 8'h02);
      rd(7'h06, 8'hA5); rd(7'h41, 8'hFF);
      run(OP_IO_OUT, 5'h00, 5'h05, 3'h0, 5'h03, 1'b0, 8'h01);
      run(OP_IO_IN, 5'h07, 5'h00, 3'h0, 5'h03, 1'b0, 8'h01);
      rd(7'h07, 8'hA5);
      run(OP_IO_BIT_FORCE_ONE, 5'h00, 5'h00, 3'h1, 5'h03, 1'b0, 8'h01);
      run(OP_IO_BIT_FORCE_ZERO, 5'h00, 5'h00, 3'h0, 5'h03, 1'b0, 8'h01);
      rd(7'h23, 8'hA6); chk8(STATUS_FLAGS, 8'h00);
      // shifts and rotates on 89 with carry in
      tbl = '{OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_CARRY_LEFT_ROTATE,
              OP_CARRY_RIGHT_ROTATE, OP_SIGNED_RIGHT_SHIFT, OP_NIBBLE_SWAP};
      er = '{8'h12, 8'h44, 8'h13, 8'hC4, 8'hC4, 8'h98};
      ef = '{8'h39, 8'h19, 8'h39, 8'h15, 8'h15, 8'h01};
      for (int i = 0; i < 6; i++) begin
         wr(7'h08, 8'h89); wr(7'h40, 8'h01);
         run(tbl[i], 5'h08, 5'h00, 3'h0, 5'h00, 1'b0, 8'h01);
         chk8(STATUS_FLAGS, ef[i]); rd(7'h08, er[i]);
      end
      // transfer flag both ways
      wr(7'h40, 8'h00); wr(7'h09, 8'h04);
      run(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h09, 3'h2, 5'h00, 1'b0, 8'h01);
      run(OP_TRANSFER_FLAG_TO_BIT, 5'h0A, 5'h00, 3'h7, 5'h00, 1'b0, 8'h01);
      chk8(STATUS_FLAGS, 8'h40); rd(7'h0A, 8'h80);
      // dedicated flag ops, then generic force one and zero on bit 7, cumulative
      wr(7'h40, 8'h00);
      for (int i = 0; i < 8; i++) begin
         run(cbae_op_t'(i < 6 ? 22 + (i % 3) * 2 + i / 3 : 16 + i - 6), 5'h00, 5'h00, 3'h7,
             5'h00, 1'b0, 8'h01);
         chk8(STATUS_FLAGS, 8'({8'h08, 8'h18, 8'h38, 8'h30, 8'h20, 8'h00, 8'h80, 8'h00}
              >> (8 * (7 - i))));
      end
      // control ops keep flags and raise their own pulse
      wr(7'h40, 8'h55);
      for (int i = 0; i < 4; i++) begin
         run(i < 3 ? cbae_op_t'(28 + i) : OP_IDLE_OP, 5'h00, 5'h00, 3'h0, 5'h00, 1'b0,
             8'h01);
         chk8({5'h00, pul}, 8'h04 >> i); chk8(STATUS_FLAGS, 8'h55);
      end
      // program store at page 01, Z FFFE, wraps into page 02
      wr(7'h00, 8'h34); wr(7'h01, 8'h12); wr(7'h1E, 8'hFE); wr(7'h1F, 8'hFF); wr(7'h43, 8'h01);
      run(OP_PROGRAM_MEMORY_STORE, 5'h00, 5'h00, 3'h0, 5'h00, 1'b0, 8'h01);
      chk8({7'h00, PMEM_WE}, 8'h01);
      chk24(PMEM_ADDR, 24'h01_FFFE); chk24({8'h00, PMEM_WDATA}, 24'h00_1234);
      rd(7'h1E, 8'h00); rd(7'h1F, 8'h00); rd(7'h43, 8'h02);
      finish_test();
   end
endmodule
